/* File: urt_serial_port.sv */
// full-duplex asynchronous serial port, 8-bit and 9-bit frames
// assumes baud_tick is a one-cycle timer overflow pulse on sys_clk and a
// processor register port of one access per cycle
`include "urt_map.svh"

// What this block does
// RULE_01: control bit 7 selects 8-bit frames when clear, 9-bit when set.
// RULE_02: 8-bit frame: start, eight data bits LSB first, stop; ten bits.
// RULE_03: 9-bit frame: start, eight data bits, ninth bit, stop; eleven bits.
// RULE_04: ninth transmit bit is sent in 9-bit mode only.
// RULE_05: writing the data buffer loads the shifter and starts a frame.
// RULE_06: transmit flag sets at the start of the stop bit.
// RULE_07: frames are received only while receive enable is set.
// RULE_08: 8-bit mode stores byte and stop bit if flag clear; multiprocessor needs stop one.
// RULE_09: 9-bit mode stores byte and ninth bit; multiprocessor needs ninth one.
// RULE_10: failed acceptance leaves latch, ninth bit and flag untouched.
// RULE_11: on overrun the earlier byte stays and the new frame is lost.
// RULE_12: interrupt request follows either flag while interrupts are enabled.
// RULE_13: hardware never clears the flags; software writes zero.
// RULE_14: receive flag sets when the stop bit is sampled.
// RULE_15: control bit 6 reads one and ignores writes.
// RULE_16: a master sends addresses with ninth bit one, data with zero.
// RULE_17: bit period is two timer overflow ticks, for both directions.
// RULE_18: receive bit timer restarts on the start edge.
// RULE_19: reading the data buffer returns the receive latch only.
// RULE_20: line is synchronised, sampled mid-bit; a short start is dropped.
module urt_serial_port
	import urt_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire urt_sfr_s sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic baud_tick,
	input wire logic port_int_enable,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic irq
);
	logic mode_q;
	logic mce_q;
	logic ren_q;
	logic tb8_q;
	logic rb8_q;
	logic ti_q;
	logic ri_q;
	logic [7:0] rx_latch_q;
	logic [7:0] rdata_q;
	logic irq_q;
	urt_tx_e tx_state_q;
	logic [7:0] tx_sh_q;
	logic [2:0] tx_cnt_q;
	logic tx_ph_q;
	logic tx_out_q;
	urt_rx_e rx_state_q;
	logic [7:0] rx_sh_q;
	logic [2:0] rx_cnt_q;
	logic rx_ph_q;
	logic rx_bit9_q;
	logic rx_prev_q;
	logic rx_lvl;

	wire ctl_wr = sfr_req.wr && (sfr_req.addr == `URT_ADDR_CTL);
	wire data_wr = sfr_req.wr && (sfr_req.addr == `URT_ADDR_DATA);
	wire [7:0] ctl_view = {mode_q, 1'b1, mce_q, ren_q, tb8_q, rb8_q, ti_q,
		ri_q}; // RULE_15
	wire [7:0] rd_sel = (sfr_req.addr == `URT_ADDR_CTL) ? ctl_view :
		(sfr_req.addr == `URT_ADDR_DATA) ? rx_latch_q : 8'h00; // RULE_19
	// a bit ends on every second overflow tick
	wire tx_bit_end = baud_tick && tx_ph_q; // RULE_17
	wire rx_sample = baud_tick && !rx_ph_q; // RULE_17
	wire tx_set_ti = tx_bit_end && ((tx_state_q == URT_TX_NINTH) ||
		((tx_state_q == URT_TX_DATA) && (tx_cnt_q == `URT_LAST_DATA_BIT) &&
		!mode_q)); // RULE_06
	wire rx_stop_smp = rx_sample && (rx_state_q == URT_RX_STOP) && ren_q;
	wire rx_ninth = mode_q ? rx_bit9_q : rx_lvl; // RULE_08 RULE_09
	wire rx_accept = rx_stop_smp && !ri_q && (!mce_q || rx_ninth); // RULE_10
	wire start_edge = (rx_state_q == URT_RX_IDLE) && ren_q && rx_prev_q &&
		!rx_lvl; // RULE_07

	urt_pin_sync u_rx_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin_in(serial_in_pin),
		.level_q(rx_lvl)
	); // RULE_20

	// control register; a hardware set beats a software clear of a flag
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= 1'b0;
			mce_q <= 1'b0;
			ren_q <= 1'b0;
			tb8_q <= 1'b0;
			rb8_q <= 1'b0;
			ti_q <= 1'b0;
			ri_q <= 1'b0;
		end else begin
			if (ctl_wr) begin
				mode_q <= sfr_req.wdata[`URT_BIT_MODE]; // RULE_01
				mce_q <= sfr_req.wdata[`URT_BIT_MCE];
				ren_q <= sfr_req.wdata[`URT_BIT_REN];
				tb8_q <= sfr_req.wdata[`URT_BIT_TB8];
			end
			if (rx_accept) begin
				rb8_q <= rx_ninth; // RULE_08 RULE_09
			end else if (ctl_wr) begin
				rb8_q <= sfr_req.wdata[`URT_BIT_RB8];
			end
			ti_q <= tx_set_ti | (ctl_wr ? sfr_req.wdata[`URT_BIT_TI] : ti_q); // RULE_13
			ri_q <= rx_accept | (ctl_wr ? sfr_req.wdata[`URT_BIT_RI] : ri_q); // RULE_14
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= `URT_DATA_RESET;
			irq_q <= 1'b0;
			rx_latch_q <= `URT_DATA_RESET;
		end else begin
			if (sfr_req.rd) begin
				rdata_q <= rd_sel;
			end
			irq_q <= (ti_q || ri_q) && port_int_enable; // RULE_12
			if (rx_accept) begin
				rx_latch_q <= rx_sh_q; // RULE_11
			end
		end
	end

	// transmitter; a write while busy restarts the frame with the new byte
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tx_state_q <= URT_TX_IDLE;
			tx_sh_q <= `URT_DATA_RESET;
			tx_cnt_q <= 3'h0;
			tx_ph_q <= 1'b0;
			tx_out_q <= 1'b1;
		end else if (data_wr) begin
			tx_state_q <= URT_TX_START; // RULE_05
			tx_sh_q <= sfr_req.wdata;
			tx_cnt_q <= 3'h0;
			tx_ph_q <= 1'b0;
			tx_out_q <= 1'b0;
		end else begin
			tx_ph_q <= tx_ph_q ^ baud_tick;
			if (tx_bit_end) begin
				unique case (tx_state_q)
					URT_TX_IDLE: begin
						tx_out_q <= 1'b1;
					end
					URT_TX_START: begin
						tx_state_q <= URT_TX_DATA;
						tx_out_q <= tx_sh_q[0]; // RULE_02
					end
					URT_TX_DATA: begin
						if (tx_cnt_q != `URT_LAST_DATA_BIT) begin
							tx_sh_q <= tx_sh_q >> 1;
							tx_out_q <= tx_sh_q[1];
							tx_cnt_q <= tx_cnt_q + 3'h1;
						end else if (mode_q) begin
							tx_state_q <= URT_TX_NINTH; // RULE_03
							tx_out_q <= tb8_q; // RULE_04
						end else begin
							tx_state_q <= URT_TX_STOP; // RULE_02
							tx_out_q <= 1'b1;
						end
					end
					URT_TX_NINTH: begin
						tx_state_q <= URT_TX_STOP;
						tx_out_q <= 1'b1;
					end
					URT_TX_STOP: begin
						tx_state_q <= URT_TX_IDLE;
						tx_out_q <= 1'b1;
					end
					default: begin
						tx_state_q <= URT_TX_IDLE;
						tx_out_q <= 1'b1;
					end
				endcase
			end
		end
	end

	// receiver; only two ticks per bit, so mid-bit is one tick after the edge
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rx_state_q <= URT_RX_IDLE;
			rx_sh_q <= `URT_DATA_RESET;
			rx_cnt_q <= 3'h0;
			rx_ph_q <= 1'b0;
			rx_bit9_q <= 1'b0;
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= rx_lvl;
			rx_ph_q <= rx_ph_q ^ baud_tick;
			if (!ren_q) begin
				rx_state_q <= URT_RX_IDLE; // RULE_07
			end else if (start_edge) begin
				rx_state_q <= URT_RX_START;
				rx_ph_q <= 1'b0; // RULE_18
				rx_cnt_q <= 3'h0;
			end else if (rx_sample) begin
				unique case (rx_state_q)
					URT_RX_IDLE: begin
						rx_cnt_q <= 3'h0;
					end
					URT_RX_START: begin
						rx_state_q <= rx_lvl ? URT_RX_IDLE : URT_RX_DATA; // RULE_20
					end
					URT_RX_DATA: begin
						rx_sh_q <= {rx_lvl, rx_sh_q[7:1]};
						rx_cnt_q <= rx_cnt_q + 3'h1;
						if (rx_cnt_q == `URT_LAST_DATA_BIT) begin
							rx_state_q <= mode_q ? URT_RX_NINTH : URT_RX_STOP;
						end
					end
					URT_RX_NINTH: begin
						rx_bit9_q <= rx_lvl; // RULE_09
						rx_state_q <= URT_RX_STOP;
					end
					URT_RX_STOP: begin
						rx_state_q <= URT_RX_IDLE; // RULE_14
					end
					default: begin
						rx_state_q <= URT_RX_IDLE;
					end
				endcase
			end
		end
	end

	assign sfr_rdata = rdata_q;
	assign serial_out_pin = tx_out_q;
	assign irq = irq_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_data_write;
		data_wr;
	endsequence
	sequence s_start_bit_out;
		(tx_state_q == URT_TX_START) && !tx_out_q;
	endsequence

	AST_BIT6_READS_ONE: assert property ( // RULE_15
		sfr_req.rd && (sfr_req.addr == `URT_ADDR_CTL) |=> rdata_q[6])
		else $error("control bit 6 did not read as one");
	AST_WRITE_STARTS_FRAME: assert property ( // RULE_05
		s_data_write |=> s_start_bit_out)
		else $error("data write did not start a frame");
	AST_TI_AT_STOP_ENTRY: assert property ( // RULE_06
		(tx_state_q == URT_TX_STOP) && ($past(tx_state_q) != URT_TX_STOP)
		|-> ti_q && tx_out_q)
		else $error("transmit flag not set at stop bit");
	AST_NINTH_BIT_SENT: assert property ( // RULE_04
		(tx_state_q == URT_TX_NINTH) && !$past(data_wr) |-> mode_q)
		else $error("ninth bit sent in 8-bit mode");
	AST_FLAG_NOT_CLEARED: assert property ( // RULE_13
		(ti_q || ri_q) && !ctl_wr |=> (ti_q || !$past(ti_q)) &&
		(ri_q || !$past(ri_q)))
		else $error("hardware cleared a flag");
	AST_OVERRUN_KEEPS_BYTE: assert property ( // RULE_11
		ri_q && !ctl_wr |=> $stable(rx_latch_q))
		else $error("receive latch overwritten while flag set");
	AST_RX_DISABLED: assert property ( // RULE_07
		!ren_q |=> rx_state_q == URT_RX_IDLE)
		else $error("receiver active while disabled");
	AST_IRQ_FOLLOWS: assert property ( // RULE_12
		(ti_q || ri_q) && port_int_enable |=> irq_q)
		else $error("interrupt request missing");
	AST_RI_AT_STOP_SAMPLE: assert property ( // RULE_14
		rx_stop_smp && !ri_q && !mce_q |=> ri_q && (rb8_q == $past(rx_ninth)))
		else $error("receive flag not set at stop sample");
endmodule

/* File: urt_map.svh */
// register addresses, field positions, reset values, last data bit and synchroniser depth of the
// serial port; assumes a byte-wide special-function-register port
`ifndef URT_MAP_SVH
`define URT_MAP_SVH
`define URT_ADDR_CTL 8'h98
`define URT_ADDR_DATA 8'h99
`define URT_CTL_RESET 8'h40
`define URT_DATA_RESET 8'h00
`define URT_BIT_MODE 7
`define URT_BIT_UNUSED 6
`define URT_BIT_MCE 5
`define URT_BIT_REN 4
`define URT_BIT_TB8 3
`define URT_BIT_RB8 2
`define URT_BIT_TI 1
`define URT_BIT_RI 0
`define URT_LAST_DATA_BIT 3'h7
`define URT_SYNC_STAGES 3
`endif

/* File: urt_pkg.sv */
// types shared by the serial port files
// assumes nothing beyond a SystemVerilog compiler
package urt_pkg;
	typedef enum logic [2:0] {
		URT_TX_IDLE = 3'h0,
		URT_TX_START = 3'h1,
		URT_TX_DATA = 3'h3,
		URT_TX_NINTH = 3'h2,
		URT_TX_STOP = 3'h6
	} urt_tx_e;
	typedef enum logic [2:0] {
		URT_RX_IDLE = 3'h0,
		URT_RX_START = 3'h1,
		URT_RX_DATA = 3'h3,
		URT_RX_NINTH = 3'h2,
		URT_RX_STOP = 3'h6
	} urt_rx_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} urt_sfr_s;
endpackage

/* File: urt_pin_sync.sv */
// three-stage synchroniser with agreement filter for an asynchronous pin
// assumes the pin idles high after reset
module urt_pin_sync (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic pin_in,
	output logic level_q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level_q <= 1'b1;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// a change counts only once two settled stages agree
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule

/* File: urt_remote_node.sv */
// remote serial node: drives the receive line, decodes the transmit line
// assumes baud_tick is the shared timer tick, one every eight clocks
module urt_remote_node (
	input wire logic sys_clk,
	input wire logic baud_tick,
	input wire logic tx_line,
	output logic rx_line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic nine_mode = 1'b0;
	logic [7:0] got_byte;
	logic got_ninth;
	logic got_stop;
	int got_cnt = 0;
	initial rx_line = 1'b1;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk iff baud_tick);
	endtask
	// bits change on a tick so the far end samples them mid-bit
	task automatic send(input logic [7:0] d, input logic b9, input logic s);
		logic [10:0] f;
		f = nine_mode ? {s, b9, d, 1'b0} : {1'b1, s, d, 1'b0};
		tick(1);
		for (int i = 0; i < (nine_mode ? 11 : 10); i++) begin
			rx_line <= f[i];
			tick(2);
		end
		rx_line <= 1'b1;
	endtask
	task automatic glitch();
		tick(1);
		rx_line <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rx_line <= 1'b1;
	endtask
	// limitation: needs the frame to start between ticks, not on one
	always begin
		@(negedge tx_line);
		tick(2);
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			got_byte[i] = tx_line;
			repeat (16) @(posedge sys_clk);
		end
		got_ninth = tx_line;
		if (nine_mode)
			repeat (16) @(posedge sys_clk);
		got_stop = tx_line;
		got_cnt++;
	end
endmodule

/* File: tb_async_serial_port_8_9_bit.sv */
// self-checking bench: register port, transmit and receive frames
// assumes the remote node model and the register map header
`include "urt_map.svh"
module tb_async_serial_port_8_9_bit
	import urt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	urt_sfr_s sfr_req = '0;
	logic [7:0] sfr_rdata;
	logic baud_tick = 1'b0;
	logic port_int_enable = 1'b0;
	logic serial_in_pin;
	logic serial_out_pin;
	logic irq;
	logic [2:0] div_q = 3'h0;
	int fails = 0;
	int comparisons = 0;
	int seed = 74;
	int n;
	int k;
	logic [7:0] v, d, lat;
	logic bt, mo, mc, en, rp, b, acc;
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		div_q <= div_q + 3'h1;
		baud_tick <= (div_q == 3'h7);
	end
	urt_serial_port urt_serial_port_inst (.sys_clk(sys_clk),
		.resetn(resetn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.baud_tick(baud_tick), .port_int_enable(port_int_enable),
		.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
		.irq(irq));
	urt_remote_node urt_remote_node_inst (.sys_clk(sys_clk),
		.baud_tick(baud_tick), .tx_line(serial_out_pin),
		.rx_line(serial_in_pin));
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge sys_clk);
		sfr_req.wr <= 1'b1;
		sfr_req.addr <= a;
		sfr_req.wdata <= w;
		@(posedge sys_clk);
		sfr_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge sys_clk);
		sfr_req.rd <= 1'b1;
		sfr_req.addr <= a;
		@(posedge sys_clk);
		sfr_req.rd <= 1'b0;
		@(posedge sys_clk);
		#1 r = sfr_rdata;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask
	task automatic stop_test();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(`URT_ADDR_CTL, v);
		chk8(v, `URT_CTL_RESET);
		rd(`URT_ADDR_DATA, v);
		chk8(v, `URT_DATA_RESET);
		rd(8'h9A, v);
		chk8(v, 8'h00);
		wr(`URT_ADDR_CTL, 8'hBF);
		rd(`URT_ADDR_CTL, v);
		chk8(v, 8'hFF);
		chk1(irq, 1'b0);
		@(posedge sys_clk);
		port_int_enable <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk1(irq, 1'b1);
		wr(`URT_ADDR_CTL, 8'hFC);
		rd(`URT_ADDR_CTL, v);
		chk8(v, 8'hFC);
		chk1(irq, 1'b0);
		// 8-bit mode sends ninth bit zero so a leak would break the stop
		for (int m = 0; m < 2; m++) begin
			d = 8'($random(seed));
			v = 8'($random(seed));
			bt = m[0] & v[0];
			urt_remote_node_inst.nine_mode = m[0];
			wr(`URT_ADDR_CTL, {m[0], 3'h0, bt, 3'h0});
			n = urt_remote_node_inst.got_cnt;
			@(posedge sys_clk iff baud_tick);
			wr(`URT_ADDR_DATA, d);
			k = 0;
			while (irq !== 1'b1 && k < 400) begin
				@(posedge sys_clk);
				k++;
			end
			#1 chk1(irq, 1'b1);
			chk1(serial_out_pin, 1'b1);
			chk1(urt_remote_node_inst.got_cnt == n, 1'b1);
			k = 0;
			while (urt_remote_node_inst.got_cnt == n && k < 100) begin
				@(posedge sys_clk);
				k++;
			end
			chk8(urt_remote_node_inst.got_byte, d);
			chk1(urt_remote_node_inst.got_ninth, m[0] ? bt : 1'b1);
			chk1(urt_remote_node_inst.got_stop, 1'b1);
			rd(`URT_ADDR_CTL, v);
			chk8(v, {m[0], 3'h4, bt, 3'h2});
		end
		lat = 8'h00;
		for (int i = 0; i < 16; i++) begin
			mo = i[0];
			mc = i[1];
			b = i[2];
			en = (i != 6);
			rp = (i >= 12);
			acc = en & ~rp & (~mc | b);
			d = 8'($random(seed));
			wr(`URT_ADDR_CTL, {mo, 1'b1, mc, en, 3'h0, rp});
			urt_remote_node_inst.nine_mode = mo;
			urt_remote_node_inst.send(d, b, mo ? i[3] : b);
			repeat (4) @(posedge sys_clk);
			rd(`URT_ADDR_CTL, v);
			chk8(v, {mo, 1'b1, mc, en, 1'b0, acc & b, 1'b0, rp | acc});
			if (acc)
				lat = d;
			rd(`URT_ADDR_DATA, v);
			chk8(v, lat);
		end
		wr(`URT_ADDR_CTL, 8'h10);
		urt_remote_node_inst.glitch();
		repeat (200) @(posedge sys_clk);
		rd(`URT_ADDR_CTL, v);
		chk8(v, 8'h50);
		stop_test();
	end
endmodule
